// ==== hdl/lic_pkg.sv ====
// package: register map, field layout and timing constants for line control
package lic_pkg;
   localparam logic [7:0] LIC_CTRL_ONE_ADDR    = 8'h10;
   localparam logic [7:0] LIC_CTRL_RESET       = 8'h00;
   localparam int         LIC_BIT_DC_OFF       = 7;
   localparam int         LIC_BIT_SPEED        = 6;
   localparam int         LIC_BIT_AC_TERM      = 5;
   localparam int         LIC_BIT_FILTER       = 4;
   localparam int         LIC_BIT_DCMODE_HI    = 3;
   localparam int         LIC_BIT_DCMODE_LO    = 2;
   localparam int         LIC_BIT_RINGER       = 1;
   localparam int         LIC_BIT_RING_THR     = 0;
   localparam int         LIC_FAST_ONHOOK_SAMP = 1024;
   localparam int         LIC_SLOW_ONHOOK_SAMP = 4096;
   localparam int         LIC_CNT_W            = 13;
   localparam int         LIC_DC_IMPED_OHM     = 800;
   localparam int         LIC_RING_LO_MIN_VRMS = 11;
   localparam int         LIC_RING_LO_MAX_VRMS = 22;
   localparam int         LIC_RING_HI_MIN_VRMS = 17;
   localparam int         LIC_RING_HI_MAX_VRMS = 33;

   typedef enum logic [1:0] {
      LIC_DCMODE_LOW_VOLT,
      LIC_DCMODE_LOWER_VOLT,
      LIC_DCMODE_STANDARD_VOLT,
      LIC_DCMODE_CURRENT_LIMIT
   } lic_dc_mode_t;

   typedef enum logic [1:0] {
      LIC_TX_MINUS5_DBM,
      LIC_TX_MINUS3_DBM,
      LIC_TX_MINUS1_DBM
   } lic_tx_level_t;

   typedef struct packed {
      logic       dc_term_off_or_squelch;
      logic       onhook_speed_select;
      logic       ac_termination_select;
      logic       iir_filter_select;
      logic [1:0] dc_termination_mode;
      logic       ringer_impedance_select;
      logic       ring_threshold_select;
   } lic_ctrl_t;

   typedef struct packed {
      logic          dc_term_disable;
      logic          dc_pin_voltage_low;
      logic          squelch_enable;
      logic          ac_complex;
      logic          iir_path;
      lic_dc_mode_t  dc_mode;
      lic_tx_level_t tx_level;
      logic          ringer_synth;
      logic          ring_thresh_high;
   } lic_line_cfg_t;
endpackage : lic_pkg

// ==== hdl/lic_onhook_counter.sv ====
// off-hook counter that times the on-hook transition in sample periods
`timescale 1ns/1ps
module lic_onhook_counter
   import lic_pkg::*;
#(
   parameter int FAST_LEN = LIC_FAST_ONHOOK_SAMP,
   parameter int SLOW_LEN = LIC_SLOW_ONHOOK_SAMP
) (
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   input  wire logic i_sample_tick,
   input  wire logic i_start,
   input  wire logic i_slow,
   output logic      o_busy,
   output logic      o_done
);
   logic [LIC_CNT_W-1:0] count_r;
   logic [LIC_CNT_W-1:0] len_r;

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         count_r <= '0;
         len_r   <= '0;
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            count_r <= '0;
            o_busy  <= 1'b1;
            len_r   <= i_slow ? LIC_CNT_W'(SLOW_LEN)
                              : LIC_CNT_W'(FAST_LEN);
         end else if (o_busy && i_sample_tick) begin
            if (count_r == len_r - LIC_CNT_W'(1)) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
            count_r <= count_r + LIC_CNT_W'(1);
         end
      end
   end
endmodule // lic_onhook_counter

// ==== hdl/lic_line_control.sv ====
// line interface control register and its decoded line configuration
// Summary of operation
// - off-hook, bit 7 set disables dc termination, 800 ohm presented
// - on-hook with newer line side, bit 7 enables ring squelch
// - older line side: bit 7 is only dc termination off, no squelch
// - on-hook speed picks off-hook counter: 1024 or 4096 samples
// - ac termination select: 0 real, 1 complex impedance
// - filter select: 0 fir on both paths, 1 iir on both paths
// - bits 3:2 pick low, lower, standard or current limiting dc mode
// - transmit level -5, -3, -1, -1 dBm following dc mode
// - dc termination off while off-hook also lowers dc pin voltage
// - ringer impedance: 0 maximum, 1 synthesized
// - ring threshold: 0 gives 11-22 Vrms, 1 gives 17-33 Vrms
`timescale 1ns/1ps
module lic_line_control
   import lic_pkg::*;
#(
   parameter int FAST_LEN = LIC_FAST_ONHOOK_SAMP,
   parameter int SLOW_LEN = LIC_SLOW_ONHOOK_SAMP
) (
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_offhook_req,
   input  wire logic       i_line_side_new,
   input  wire logic       i_sample_tick,
   output logic            o_offhook,
   output logic            o_onhook_busy,
   output lic_line_cfg_t   o_cfg
);
   lic_ctrl_t     ctrl_r;
   lic_line_cfg_t cfg_nxt;
   logic          offhook_r;
   logic          cnt_busy;
   logic          cnt_done;
   logic          start_onhook;

   // register write; reads leave state alone
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         ctrl_r <= lic_ctrl_t'(LIC_CTRL_RESET);
      end else if (i_wr && i_addr == LIC_CTRL_ONE_ADDR) begin
         ctrl_r <= lic_ctrl_t'(i_wdata);
      end
   end

   // read data one cycle after the strobe, zero for unmapped addresses
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else if (i_rd && i_addr == LIC_CTRL_ONE_ADDR) begin
         o_rdata <= ctrl_r;
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // hook state: off-hook at once, on-hook after the off-hook counter
   // done blocks a restart in the cycle before the hook drops
   assign start_onhook = offhook_r && !i_offhook_req && !cnt_busy &&
                         !cnt_done;

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         offhook_r <= 1'b0;
      end else if (i_offhook_req) begin
         offhook_r <= 1'b1;
      end else if (cnt_done) begin
         offhook_r <= 1'b0;
      end
   end

   lic_onhook_counter #(
      .FAST_LEN (FAST_LEN),
      .SLOW_LEN (SLOW_LEN)
   ) u_onhook_counter (
      .i_clock       (i_clock),
      .i_rst_b       (i_rst_b),
      .i_sample_tick (i_sample_tick),
      .i_start       (start_onhook),
      .i_slow        (ctrl_r.onhook_speed_select),
      .o_busy        (cnt_busy),
      .o_done        (cnt_done)
   );

   // configuration decode
   always_comb begin
      cfg_nxt = '0;
      cfg_nxt.dc_term_disable  = ctrl_r.dc_term_off_or_squelch &&
                                 (offhook_r || !i_line_side_new);
      cfg_nxt.dc_pin_voltage_low = ctrl_r.dc_term_off_or_squelch &&
                                   offhook_r;
      cfg_nxt.squelch_enable   = ctrl_r.dc_term_off_or_squelch &&
                                 !offhook_r && i_line_side_new;
      cfg_nxt.ac_complex       = ctrl_r.ac_termination_select;
      cfg_nxt.iir_path         = ctrl_r.iir_filter_select;
      cfg_nxt.dc_mode = lic_dc_mode_t'(ctrl_r.dc_termination_mode);
      unique case (cfg_nxt.dc_mode)
         LIC_DCMODE_LOW_VOLT:      cfg_nxt.tx_level = LIC_TX_MINUS5_DBM;
         LIC_DCMODE_LOWER_VOLT:    cfg_nxt.tx_level = LIC_TX_MINUS3_DBM;
         LIC_DCMODE_STANDARD_VOLT: cfg_nxt.tx_level = LIC_TX_MINUS1_DBM;
         LIC_DCMODE_CURRENT_LIMIT: cfg_nxt.tx_level = LIC_TX_MINUS1_DBM;
      endcase
      cfg_nxt.ringer_synth     = ctrl_r.ringer_impedance_select;
      cfg_nxt.ring_thresh_high = ctrl_r.ring_threshold_select;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_cfg <= '0;
      end else begin
         o_cfg <= cfg_nxt;
      end
   end

   assign o_offhook     = offhook_r;
   assign o_onhook_busy = cnt_busy;

   // checks: register port
   readback_value_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      i_wr && i_addr == LIC_CTRL_ONE_ADDR ##1
      i_rd && i_addr == LIC_CTRL_ONE_ADDR && !i_wr |=>
      o_rdata == $past(i_wdata, 2))
      else $error("read does not return last write");
   unmapped_read_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      !(i_rd && i_addr == LIC_CTRL_ONE_ADDR) |=> o_rdata == 8'h00)
      else $error("read data not zero");
   write_update_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      i_wr && i_addr == LIC_CTRL_ONE_ADDR |=>
      ctrl_r == $past(i_wdata))
      else $error("write did not update the register");
   write_ignored_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      !(i_wr && i_addr == LIC_CTRL_ONE_ADDR) |=> $stable(ctrl_r))
      else $error("register changed without a mapped write");

   // checks: hook state and on-hook counter
   offhook_set_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      i_offhook_req |=> offhook_r)
      else $error("off-hook request not taken");
   onhook_start_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      start_onhook |=> cnt_busy && offhook_r)
      else $error("on-hook counter not started");
   onhook_drop_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      cnt_done && !i_offhook_req |=> !offhook_r && !cnt_busy)
      else $error("hook did not drop after the counter");
   request_wins_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      cnt_done && i_offhook_req |=> offhook_r)
      else $error("off-hook request lost at counter end");
   early_drop_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      offhook_r && !cnt_done |=> offhook_r)
      else $error("hook dropped before the counter ended");
   busy_offhook_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      cnt_busy |-> offhook_r)
      else $error("counter running while on-hook");

   // check helper: sample ticks seen while the counter runs
   logic [LIC_CNT_W:0] chk_ticks_r;
   logic               chk_slow_r;
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         chk_ticks_r <= '0;
         chk_slow_r  <= 1'b0;
      end else if (start_onhook) begin
         chk_ticks_r <= '0;
         chk_slow_r  <= ctrl_r.onhook_speed_select;
      end else if (cnt_busy && i_sample_tick) begin
         chk_ticks_r <= chk_ticks_r + (LIC_CNT_W+1)'(1);
      end
   end
   onhook_length_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      cnt_done |-> chk_ticks_r ==
      (chk_slow_r ? (LIC_CNT_W+1)'(SLOW_LEN)
                  : (LIC_CNT_W+1)'(FAST_LEN)))
      else $error("on-hook counter length wrong");

   // checks: decoded line configuration
   dc_off_hook_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      offhook_r && ctrl_r.dc_term_off_or_squelch |=>
      o_cfg.dc_term_disable && o_cfg.dc_pin_voltage_low)
      else $error("dc termination not disabled off-hook");
   pin_voltage_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      !offhook_r |=> !o_cfg.dc_pin_voltage_low)
      else $error("dc pin lowered on-hook");
   squelch_onhook_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      !offhook_r && i_line_side_new |=>
      o_cfg.squelch_enable == $past(ctrl_r.dc_term_off_or_squelch))
      else $error("squelch wrong on-hook");
   squelch_offhook_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      offhook_r |=> !o_cfg.squelch_enable)
      else $error("squelch seen off-hook");
   dc_on_onhook_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      !offhook_r && i_line_side_new |=> !o_cfg.dc_term_disable)
      else $error("dc termination off while squelch capable on-hook");
   old_side_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      !i_line_side_new |=> !o_cfg.squelch_enable &&
      o_cfg.dc_term_disable == $past(ctrl_r.dc_term_off_or_squelch))
      else $error("older line side squelch seen");
   tx_level_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      ##1 o_cfg.tx_level ==
      (o_cfg.dc_mode == LIC_DCMODE_LOW_VOLT ? LIC_TX_MINUS5_DBM :
       o_cfg.dc_mode == LIC_DCMODE_LOWER_VOLT ? LIC_TX_MINUS3_DBM :
       LIC_TX_MINUS1_DBM))
      else $error("transmit level mismatch");
   ac_term_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=> o_cfg.ac_complex == $past(ctrl_r.ac_termination_select))
      else $error("ac termination select mismatch");
   filter_path_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=> o_cfg.iir_path == $past(ctrl_r.iir_filter_select))
      else $error("filter select mismatch");
   dc_mode_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=> o_cfg.dc_mode == $past(ctrl_r.dc_termination_mode))
      else $error("dc termination mode mismatch");
   ringer_imp_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=> o_cfg.ringer_synth == $past(ctrl_r.ringer_impedance_select))
      else $error("ringer impedance select mismatch");
   ring_thresh_a: assert property (
      @(posedge i_clock) disable iff (!i_rst_b)
      1'b1 |=>
      o_cfg.ring_thresh_high == $past(ctrl_r.ring_threshold_select))
      else $error("ring threshold select mismatch");
endmodule // lic_line_control

// ==== sim/lic_host_model.sv ====
// host model: drives the register port as the serial port host does
`timescale 1ns/1ps
module lic_host_model (
   input  wire logic       i_clock,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd,
   input  wire logic [7:0] i_rdata
);
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge i_clock);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clock);
      o_rd <= 1'b0;
      @(negedge i_clock);
      q = i_rdata;
   endtask
endmodule // lic_host_model

// ==== sim/lic_line_control_test.sv ====
// testbench for the line interface control register
`timescale 1ns/1ps
module lic_line_control_test;
   import lic_pkg::*;
   logic          clk = 1'b0, rst_b = 1'b0;
   logic          req = 1'b0, nw = 1'b1, tick = 1'b0;
   logic [7:0]    addr, wdata, rdata, q;
   logic          wr, rd, offhook, busy;
   lic_line_cfg_t cfg;
   int            bad_count = 0, comparisons = 0, cyc = 0, n;
   always #2 clk = ~clk;
   lic_host_model i_host (.i_clock(clk), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   lic_line_control #(.FAST_LEN(4), .SLOW_LEN(16)) i_dut (.i_clock(clk),
      .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_offhook_req(req),
      .i_line_side_new(nw), .i_sample_tick(tick), .o_offhook(offhook),
      .o_onhook_busy(busy), .o_cfg(cfg));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic t_reset();
      i_host.rd(LIC_CTRL_ONE_ADDR, q);
      check(q, LIC_CTRL_RESET);
      check(cfg, 16'h0000);
      check(offhook, 1'b0);
   endtask
   task automatic t_rw();
      logic [7:0] v[3] = '{8'hA5, 8'h5A, 8'hFF};
      foreach (v[i]) begin
         i_host.wr(LIC_CTRL_ONE_ADDR, v[i]);
         i_host.rd(LIC_CTRL_ONE_ADDR, q);
         check(q, v[i]);
      end
      i_host.wr(8'h11, 8'h00);
      i_host.rd(8'h11, q);
      check(q, 8'h00);
      i_host.rd(LIC_CTRL_ONE_ADDR, q);
      check(q, 8'hFF);
   endtask
   task automatic t_fields();
      for (int i = 0; i < 4; i++) begin
         i_host.wr(LIC_CTRL_ONE_ADDR, {2'b00, i[0], i[1], i[1:0], i[1], i[0]});
         repeat (2) @(negedge clk);
         check(cfg.ac_complex, i[0]);
         check(cfg.iir_path, i[1]);
         check(cfg.dc_mode, i[1:0]);
         check(cfg.tx_level, 16'((i == 3) ? 2 : i));
         check(cfg.ringer_synth, i[1]);
         check(cfg.ring_thresh_high, i[0]);
      end
   endtask
   task automatic t_bit7();
      i_host.wr(LIC_CTRL_ONE_ADDR, 8'h80);
      repeat (2) @(negedge clk);
      check({cfg.squelch_enable, cfg.dc_term_disable}, 2'b10);
      @(posedge clk) nw <= 1'b0;
      repeat (2) @(negedge clk);
      check({cfg.squelch_enable, cfg.dc_term_disable}, 2'b01);
      check(cfg.dc_pin_voltage_low, 1'b0);
      @(posedge clk) nw <= 1'b1;
      req <= 1'b1;
      repeat (3) @(negedge clk);
      check({cfg.squelch_enable, cfg.dc_term_disable}, 2'b01);
      check(cfg.dc_pin_voltage_low, 1'b1);
   endtask
   task automatic t_onhook(input logic slow, input int len);
      i_host.wr(LIC_CTRL_ONE_ADDR, {1'b0, slow, 6'h00});
      @(posedge clk) req <= 1'b1;
      repeat (3) @(negedge clk);
      check(offhook, 1'b1);
      @(posedge clk) req <= 1'b0;
      repeat (2) @(negedge clk);
      check(busy, 1'b1);
      n = 0;
      while (offhook === 1'b1 && n < 40) begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
         repeat (3) @(negedge clk);
         n++;
      end
      check(16'(n), 16'(len));
      check(busy, 1'b0);
   endtask
   task automatic t_rehook();
      i_host.wr(LIC_CTRL_ONE_ADDR, 8'h00);
      @(posedge clk) req <= 1'b1;
      repeat (2) @(posedge clk);
      req <= 1'b0;
      repeat (2) @(posedge clk);
      req <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         repeat (4) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
         end
         repeat (3) @(negedge clk);
         check(offhook, k == 0);
         check(busy, 1'b0);
         @(posedge clk) req <= 1'b0;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_rw();
      t_fields();
      t_bit7();
      t_onhook(1'b0, 4);
      t_onhook(1'b1, 16);
      t_rehook();
      summarize();
   end
endmodule // lic_line_control_test
